// ### rtl/rps_pkg.sv
/*
 * rps_pkg: register map, field positions, reset values and decoded
 * configuration types for the protocol select and tx framing options block.
 * assumes a single 50 MHz clock domain and a 32-bit avalon-mm register bus.
 */
package rps_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0]  PROTO_SEL_IDX   = 8'h01;
   localparam logic [7:0]  TX_FRAME_IDX    = 8'h02;
   localparam logic [7:0]  CFG_STATUS_IDX  = 8'h10;
   localparam logic [7:0]  PROTO_SEL_RST   = 8'h02;
   localparam logic [7:0]  TX_FRAME_RST    = 8'h00;
   localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

   // ****************************************************************
   // protocol select field positions
   // ****************************************************************
   localparam int PS_FAMILY_BIT = 5;
   localparam int PS_EMUL_BIT   = 2;

   // ****************************************************************
   // tx framing options field positions
   // ****************************************************************
   localparam int TF_GUARD_LSB  = 5;
   localparam int TF_EOF_LOW    = 4;
   localparam int TF_SOF_HIGH   = 3;
   localparam int TF_SOF_LOW    = 2;
   localparam int TF_GUARD_LAST = 1;
   localparam int TF_LAYER4     = 0;

   // ****************************************************************
   // frame timing in elementary time units
   // ****************************************************************
   localparam logic [3:0] EOF_LOW_LONG_ETU   = 4'd11;
   localparam logic [3:0] EOF_LOW_SHORT_ETU  = 4'd10;
   localparam logic [3:0] SOF_HIGH_LONG_ETU  = 4'd3;
   localparam logic [3:0] SOF_HIGH_SHORT_ETU = 4'd2;
   localparam logic [3:0] SOF_LOW_LONG_ETU   = 4'd11;
   localparam logic [3:0] SOF_LOW_SHORT_ETU  = 4'd10;

   // ****************************************************************
   // decoded configuration types
   // ****************************************************************
   typedef enum logic [3:0] {
      PROTO_VICINITY,
      PROTO_PROX_A,
      PROTO_PROX_B,
      PROTO_MANCHESTER,
      PROTO_NFC,
      PROTO_EMUL_A,
      PROTO_EMUL_B,
      PROTO_INVALID
   } rps_proto_type;

   // receive rate codes: 0 = 6.62/6.67k, 1 = 26.48/26.69k, 2 = 106k, 3 = 212k, 4 = 424k, 5 = 848k, 6 = none
   typedef enum logic [2:0] {
      RATE_VIC_LOW,
      RATE_VIC_HIGH,
      RATE_106K,
      RATE_212K,
      RATE_424K,
      RATE_848K,
      RATE_NONE
   } rps_rate_type;

   typedef struct packed {
      rps_proto_type proto;
      rps_rate_type  rate;
      logic          double_subcarrier;
      logic          coding_256;
      logic          nfc_family;
   } rps_proto_cfg_type;

   typedef struct packed {
      logic [2:0] guard_etu;
      logic       guard_after_last;
      logic [3:0] eof_low_etu;
      logic [3:0] sof_high_etu;
      logic [3:0] sof_low_etu;
      logic       layer4_enable;
      logic       layer4_bit;
   } rps_tx_cfg_type;

endpackage : rps_pkg

// ### rtl/rps_proto_decode.sv
/*
 * rps_proto_decode: combinational decode of the protocol select register
 * into protocol, rate and coding choices.
 * assumes the register value is stable and registered upstream.
 */
module rps_proto_decode
   import rps_pkg::*;
(
   input  wire logic [7:0]        i_select, // protocol select register value
   output rps_proto_cfg_type      o_cfg     // decoded configuration
);

   // ****************************************************************
   // low two bits to a 106..848k rate
   // ****************************************************************
   function automatic rps_rate_type rate_of(input logic [1:0] code);
      unique case (code)
         2'b00: rate_of = RATE_106K;
         2'b01: rate_of = RATE_212K;
         2'b10: rate_of = RATE_424K;
         2'b11: rate_of = RATE_848K;
      endcase
   endfunction : rate_of

   always_comb begin
      o_cfg                   = '0;
      o_cfg.proto             = PROTO_INVALID;
      o_cfg.rate              = RATE_NONE;
      o_cfg.nfc_family        = i_select[PS_FAMILY_BIT];
      if (i_select[PS_FAMILY_BIT]) begin
         if (i_select[PS_EMUL_BIT]) begin
            unique case (i_select[1:0])
               2'b00: o_cfg.proto = PROTO_EMUL_A;
               2'b01: o_cfg.proto = PROTO_EMUL_B;
               default: o_cfg.proto = PROTO_INVALID;
            endcase
            if (i_select[1] == 1'b0) begin
               o_cfg.rate = RATE_106K;
            end
         end else begin
            if (i_select[1:0] != 2'b00) begin
               o_cfg.proto = PROTO_NFC;
               o_cfg.rate  = (i_select[1:0] == 2'b01) ? RATE_106K :
                             (i_select[1:0] == 2'b10) ? RATE_212K : RATE_424K;
            end
         end
      end else begin
         unique case (i_select[4:2])
            3'b000, 3'b001: begin
               o_cfg.proto             = PROTO_VICINITY;
               o_cfg.coding_256        = i_select[0];
               o_cfg.rate              = i_select[1] ? RATE_VIC_HIGH : RATE_VIC_LOW;
               o_cfg.double_subcarrier = i_select[2];
            end
            3'b010: begin
               o_cfg.proto = PROTO_PROX_A;
               o_cfg.rate  = rate_of(i_select[1:0]);
            end
            3'b011: begin
               o_cfg.proto = PROTO_PROX_B;
               o_cfg.rate  = rate_of(i_select[1:0]);
            end
            3'b110: begin
               if (i_select[1]) begin
                  o_cfg.proto = PROTO_MANCHESTER;
                  o_cfg.rate  = i_select[0] ? RATE_424K : RATE_212K;
               end
            end
            default: o_cfg.proto = PROTO_INVALID;
         endcase
      end
   end

endmodule : rps_proto_decode

// ### rtl/rps_top.sv
/*
 * rps_top: protocol select and tx framing options register bank with an
 * avalon-mm slave, decode of both registers and a guard-time sequencer
 * that tells the framer when a character may follow.
 * assumes one 50 MHz clock, synchronous active-low reset, a framer that
 * pulses i_char_done per transmitted character and an etu tick input.
 */
//
// Summary of operation
// - vicinity mode: select bit 0 picks one-of-four or one-of-256 coding
// - vicinity single subcarrier: select bit 1 picks 6.62 or 26.48 kbps
// - select bit 2 with upper bits zero picks double subcarrier response
// - code 00010 is the reader default
// - codes 01000..01011 pick type A with rx rate 106..848 kbps
// - codes 01100..01111 pick type B with rx rate 106..848 kbps
// - nfc mode low bits pick 106, 212 or 424 kbps; 00 invalid
// - emulation low bits pick type A or B card; 10 and 11 invalid
// - type B tx inserts 0..7 etu guard time between characters
// - guard-after-last flag keeps guard after final byte, else omitted
// - end-of-frame low phase is 11 etu when set, 10 when clear
// - start-of-frame high phase is 3 etu when set, 2 when clear
// - type B start-of-frame low phase is 11 etu when set, 10 when clear
// - layer-4 flag drives select-acknowledge bit 6 only for type A or type A emulation in auto anticollision
// - tx options register resets to 0x00 on reset or enable low
// - select bit 5 picks reader family or nfc/emulation family
// - protocol register presets to 0x02 on reset or enable low
module rps_top
   import rps_pkg::*;
(
   input  wire logic              i_clock,          // 50 MHz system clock
   input  wire logic              i_nrst,           // synchronous reset, active low
   input  wire logic              i_enable,         // device enable, low holds presets
   input  wire logic [7:0]        i_avs_address,    // word index
   input  wire logic              i_avs_read,       // read request
   input  wire logic              i_avs_write,      // write request
   input  wire logic [31:0]       i_avs_writedata,  // write data
   input  wire logic [3:0]        i_avs_byteenable, // byte lanes
   output logic [31:0]            o_avs_readdata,   // read data
   output logic                   o_avs_waitrequest,// stall
   input  wire logic              i_auto_ac,        // automatic anticollision active
   input  wire logic              i_etu_tick,       // one pulse per elementary time unit
   input  wire logic              i_char_done,      // pulse: character sent
   input  wire logic              i_last_char,      // level: that character was final
   output rps_proto_cfg_type      o_proto_cfg,      // decoded protocol
   output rps_tx_cfg_type         o_tx_cfg,         // decoded framing
   output logic [7:0]             o_sak_response,   // select-acknowledge byte
   output logic                   o_char_ready      // next character may be sent
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef enum logic [1:0] {
      GS_IDLE,
      GS_GUARD
   } rps_guard_type;

   typedef struct packed {
      logic [7:0]    proto_sel;
      logic [7:0]    tx_frame;
      logic          ack;
      logic [31:0]   rdata;
      rps_guard_type guard;
      logic [2:0]    guard_cnt;
   } rps_state_type;

   rps_state_type state_reg;
   rps_state_type state_next;

   rps_proto_cfg_type proto_cfg;
   rps_tx_cfg_type    tx_cfg;

   // ****************************************************************
   // decoders
   // ****************************************************************
   rps_proto_decode u_proto (
      .i_select (state_reg.proto_sel),
      .o_cfg    (proto_cfg)
   );

   rps_tx_decode u_tx (
      .i_options (state_reg.tx_frame),
      .i_proto   (proto_cfg.proto),
      .i_auto_ac (i_auto_ac),
      .o_cfg     (tx_cfg)
   );

   // byte lane 0 merge; upper lanes hold nothing
   function automatic logic [7:0] merge_low(input logic [7:0] old_val,
                                            input logic [31:0] wdata,
                                            input logic [3:0] be);
      merge_low = be[0] ? wdata[7:0] : old_val;
   endfunction : merge_low

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      state_next     = state_reg;
      state_next.ack = 1'b0;
      if ((i_avs_read || i_avs_write) && !state_reg.ack) begin
         state_next.ack   = 1'b1;
         state_next.rdata = UNMAPPED_DATA;
         unique case (i_avs_address)
            PROTO_SEL_IDX: begin
               state_next.rdata = {24'h00_0000, state_reg.proto_sel};
               if (i_avs_write) begin
                  state_next.proto_sel = merge_low(state_reg.proto_sel, i_avs_writedata, i_avs_byteenable);
               end
            end
            TX_FRAME_IDX: begin
               state_next.rdata = {24'h00_0000, state_reg.tx_frame};
               if (i_avs_write) begin
                  state_next.tx_frame = merge_low(state_reg.tx_frame, i_avs_writedata, i_avs_byteenable);
               end
            end
            CFG_STATUS_IDX: begin
               state_next.rdata = {21'h00_0000, proto_cfg.nfc_family, proto_cfg.double_subcarrier,
                                   proto_cfg.coding_256, proto_cfg.rate, proto_cfg.proto,
                                   state_reg.guard == GS_GUARD};
            end
            default: state_next.rdata = UNMAPPED_DATA;
         endcase
      end

      // guard time sequencer for type B characters
      unique case (state_reg.guard)
         GS_IDLE: begin
            if (i_char_done && proto_cfg.proto == PROTO_PROX_B && tx_cfg.guard_etu != 3'd0 &&
                (tx_cfg.guard_after_last || !i_last_char)) begin
               state_next.guard     = GS_GUARD;
               state_next.guard_cnt = tx_cfg.guard_etu;
            end
         end
         GS_GUARD: begin
            if (i_etu_tick) begin
               state_next.guard_cnt = state_reg.guard_cnt - 3'd1;
               if (state_reg.guard_cnt == 3'd1) begin
                  state_next.guard = GS_IDLE;
               end
            end
         end
      endcase

      if (!i_enable) begin
         state_next.proto_sel = PROTO_SEL_RST;
         state_next.tx_frame  = TX_FRAME_RST;
         state_next.guard     = GS_IDLE;
         state_next.guard_cnt = 3'd0;
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         state_reg           <= '0;
         state_reg.proto_sel <= PROTO_SEL_RST;
         state_reg.tx_frame  <= TX_FRAME_RST;
         state_reg.guard     <= GS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !state_reg.ack;
   assign o_avs_readdata    = state_reg.rdata;
   assign o_proto_cfg       = proto_cfg;
   assign o_tx_cfg          = tx_cfg;
   assign o_sak_response    = {1'b0, tx_cfg.layer4_bit, 6'b00_0000};
   assign o_char_ready      = (state_reg.guard == GS_IDLE);

endmodule : rps_top

// ### rtl/rps_tx_decode.sv
/*
 * rps_tx_decode: combinational decode of the tx framing options register
 * into guard time and frame lengths in elementary time units.
 * assumes the decoded protocol comes from rps_proto_decode.
 */
module rps_tx_decode
   import rps_pkg::*;
(
   input  wire logic [7:0]        i_options, // tx framing options value
   input  wire rps_proto_type     i_proto,   // decoded protocol
   input  wire logic              i_auto_ac, // automatic anticollision active
   output rps_tx_cfg_type         o_cfg      // decoded framing
);

   always_comb begin
      o_cfg                  = '0;
      if (i_proto == PROTO_PROX_B) begin
         o_cfg.guard_etu   = i_options[TF_GUARD_LSB +: 3];
         o_cfg.sof_low_etu = i_options[TF_SOF_LOW] ? SOF_LOW_LONG_ETU : SOF_LOW_SHORT_ETU;
      end
      o_cfg.guard_after_last = i_options[TF_GUARD_LAST];
      o_cfg.eof_low_etu      = i_options[TF_EOF_LOW] ? EOF_LOW_LONG_ETU : EOF_LOW_SHORT_ETU;
      o_cfg.sof_high_etu     = i_options[TF_SOF_HIGH] ? SOF_HIGH_LONG_ETU : SOF_HIGH_SHORT_ETU;
      o_cfg.layer4_enable    = i_auto_ac && (i_proto == PROTO_PROX_A || i_proto == PROTO_EMUL_A);
      o_cfg.layer4_bit       = o_cfg.layer4_enable & i_options[TF_LAYER4];
   end

endmodule : rps_tx_decode

// ### test/rps_framer_model.sv
/* rps_framer_model: framer that sends characters and makes etu ticks.
   assumes the bench calls send_char and feeds back o_char_ready. */
module rps_framer_model #(
   parameter int ETU_CYC = 4
) (
   input  wire logic i_clock,      // clock
   input  wire logic i_char_ready, // guard idle
   output logic      o_etu_tick,   // etu pulse
   output logic      o_char_done,  // char sent pulse
   output logic      o_last_char   // final char flag
);
   timeunit 1ns;
   timeprecision 1ns;
   int div = 0;
   initial begin
      o_etu_tick = 1'b0;
      o_char_done = 1'b0;
      o_last_char = 1'b0;
   end
   always @(posedge i_clock) begin
      div <= (div == ETU_CYC - 1) ? 0 : div + 1;
      o_etu_tick <= (div == ETU_CYC - 1);
   end
   // a character leaves only when the guard is idle, just after a tick
   task automatic send_char(input logic last);
      @(posedge i_clock);
      while (!(i_char_ready && o_etu_tick)) @(posedge i_clock);
      o_char_done <= 1'b1;
      o_last_char <= last;
      @(posedge i_clock);
      o_char_done <= 1'b0;
      o_last_char <= ~last;
   endtask : send_char
endmodule : rps_framer_model

// ### test/rps_top_props.sv
/* rps_top_props: port assertions for rps_top.
   assumes a bind onto rps_top and one clock domain. */
module rps_top_props
   import rps_pkg::*;
(
   input wire logic              i_clock,          // clock
   input wire logic              i_nrst,           // sync reset
   input wire logic              i_enable,         // enable
   input wire logic [7:0]        i_avs_address,    // word index
   input wire logic              i_avs_read,       // read
   input wire logic              i_avs_write,      // write
   input wire logic [31:0]       i_avs_writedata,  // write data
   input wire logic [3:0]        i_avs_byteenable, // lanes
   input wire logic              o_avs_waitrequest,// stall
   input wire logic              i_auto_ac,        // anticollision
   input wire logic              i_char_done,      // char sent
   input wire logic              i_last_char,      // final char
   input wire rps_proto_cfg_type o_proto_cfg,      // protocol
   input wire rps_tx_cfg_type    o_tx_cfg,         // framing
   input wire logic [7:0]        o_sak_response,   // sak byte
   input wire logic              o_char_ready      // guard idle
);
   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   wire wr_tx = i_avs_write && !o_avs_waitrequest && i_avs_address == TX_FRAME_IDX && i_avs_byteenable[0] && i_enable;
   property p_wait;
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("no answer after one wait state");
   property p_proto_rst;
      disable iff (1'b0) !i_nrst |=> o_proto_cfg.proto == PROTO_VICINITY && o_proto_cfg.rate == RATE_VIC_HIGH
         && !o_proto_cfg.coding_256 && !o_proto_cfg.double_subcarrier;
   endproperty
   a_proto_rst: assert property (p_proto_rst) else $error("protocol preset wrong");
   property p_tx_rst;
      disable iff (1'b0) !i_nrst |=> o_tx_cfg.eof_low_etu == EOF_LOW_SHORT_ETU
         && o_tx_cfg.sof_high_etu == SOF_HIGH_SHORT_ETU && o_tx_cfg.guard_etu == 3'd0 && o_char_ready;
   endproperty
   a_tx_rst: assert property (p_tx_rst) else $error("framing reset wrong");
   property p_en_low;
      !i_enable |=> o_proto_cfg.rate == RATE_VIC_HIGH && o_tx_cfg.eof_low_etu == EOF_LOW_SHORT_ETU;
   endproperty
   a_en_low: assert property (p_en_low) else $error("enable low does not preset");
   property p_eof;
      wr_tx ##1 i_enable |-> o_tx_cfg.eof_low_etu ==
         ($past(i_avs_writedata[TF_EOF_LOW]) ? EOF_LOW_LONG_ETU : EOF_LOW_SHORT_ETU);
   endproperty
   a_eof: assert property (p_eof) else $error("eof low length wrong");
   property p_sof_high;
      wr_tx ##1 i_enable |-> o_tx_cfg.sof_high_etu ==
         ($past(i_avs_writedata[TF_SOF_HIGH]) ? SOF_HIGH_LONG_ETU : SOF_HIGH_SHORT_ETU);
   endproperty
   a_sof_high: assert property (p_sof_high) else $error("sof high length wrong");
   property p_not_b;
      o_proto_cfg.proto != PROTO_PROX_B |-> o_tx_cfg.sof_low_etu == 4'd0 && o_tx_cfg.guard_etu == 3'd0;
   endproperty
   a_not_b: assert property (p_not_b) else $error("type b field outside type b");
   property p_sak;
      o_sak_response == (i_auto_ac ? {1'b0, o_tx_cfg.layer4_bit, 6'd0} : 8'h00);
   endproperty
   a_sak: assert property (p_sak) else $error("sak byte wrong");
   property p_guard_go;
      i_char_done && o_char_ready && o_proto_cfg.proto == PROTO_PROX_B && o_tx_cfg.guard_etu != 3'd0
         && (o_tx_cfg.guard_after_last || !i_last_char) |=> !o_char_ready;
   endproperty
   a_guard_go: assert property (p_guard_go) else $error("guard did not start");
   property p_guard_skip;
      i_char_done && o_char_ready && i_last_char && !o_tx_cfg.guard_after_last |=> o_char_ready;
   endproperty
   a_guard_skip: assert property (p_guard_skip) else $error("guard after last byte");
   property p_family;
      o_proto_cfg.nfc_family |-> o_proto_cfg.proto inside {PROTO_NFC, PROTO_EMUL_A, PROTO_EMUL_B, PROTO_INVALID};
   endproperty
   a_family: assert property (p_family) else $error("family bit ignored");
endmodule : rps_top_props

bind rps_top rps_top_props rps_top_props_inst (.i_clock, .i_nrst, .i_enable, .i_avs_address, .i_avs_read,
   .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_waitrequest, .i_auto_ac, .i_char_done,
   .i_last_char, .o_proto_cfg, .o_tx_cfg, .o_sak_response, .o_char_ready);

// ### test/rps_top_tb.sv
/* rps_top_tb: register, decode and guard tests for rps_top.
   assumes rps_framer_model as framer and the bound checker. */
module rps_top_tb
   import rps_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, nrst = 0, enable = 1, avs_read = 0, avs_write = 0, auto_ac = 0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, rq;
   logic [3:0]  be = 4'h0;
   logic waitreq, ready, tick, cdone, clast;
   logic [7:0] sak;
   rps_proto_cfg_type pcfg;
   rps_tx_cfg_type tcfg;
   int error_cnt = 0, checked = 0, n;
   logic [7:0] protos [4] = '{8'h02, 8'h08, 8'h0C, 8'h24};
   logic [7:0] opts [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
   rps_top rps_top_inst (.i_clock(clock), .i_nrst(nrst), .i_enable(enable), .i_avs_address(addr),
      .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(wdata), .i_avs_byteenable(be),
      .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_auto_ac(auto_ac), .i_etu_tick(tick),
      .i_char_done(cdone), .i_last_char(clast), .o_proto_cfg(pcfg), .o_tx_cfg(tcfg),
      .o_sak_response(sak), .o_char_ready(ready));
   rps_framer_model rps_framer_model_inst (.i_clock(clock), .i_char_ready(ready), .o_etu_tick(tick),
      .o_char_done(cdone), .o_last_char(clast));
   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
      @(posedge clock);
      addr <= a; wdata <= d; be <= b; avs_write <= w; avs_read <= !w;
      @(posedge clock);
      // only the watchdog ends a stalled access
      while (waitreq !== 1'b0) begin
         @(posedge clock);
      end
      rq = rdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0000_00, d}, 4'hF);
   endtask : bus_write
   task automatic bus_read(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, 4'hF);
      cmp(rq, exp);
   endtask : bus_read
   task automatic check_proto(input logic [7:0] c);
      logic [3:0] p;
      logic [2:0] r;
      p = PROTO_INVALID;
      r = RATE_NONE;
      if (!c[5] && c[4:3] == 2'b00) begin
         p = PROTO_VICINITY;
         r = c[1] ? RATE_VIC_HIGH : RATE_VIC_LOW;
      end else if (!c[5] && !c[4]) begin
         p = c[2] ? PROTO_PROX_B : PROTO_PROX_A;
         r = RATE_106K + {1'b0, c[1:0]};
      end else if (!c[5] && c[4:1] == 4'b1101) begin
         p = PROTO_MANCHESTER;
         r = c[0] ? RATE_424K : RATE_212K;
      end else if (c[5] && !c[2] && c[1:0] != 2'b00) begin
         p = PROTO_NFC;
         r = RATE_106K + {1'b0, c[1:0]} - 3'd1;
      end else if (c[5] && c[2] && !c[1]) p = c[0] ? PROTO_EMUL_B : PROTO_EMUL_A;
      #1;
      cmp(pcfg.proto, p);
      cmp(pcfg.nfc_family, c[5]);
      if (p != PROTO_INVALID && p < PROTO_EMUL_A) cmp(pcfg.rate, r);
      if (p == PROTO_VICINITY) cmp({pcfg.double_subcarrier, pcfg.coding_256}, {c[2], c[0]});
   endtask : check_proto
   task automatic check_tx(input logic [7:0] p, input logic [7:0] o);
      logic isb;
      logic isa;
      isb = (p == 8'h0C);
      isa = (p == 8'h08 || p == 8'h24);
      #1;
      cmp(tcfg.eof_low_etu, o[TF_EOF_LOW] ? EOF_LOW_LONG_ETU : EOF_LOW_SHORT_ETU);
      cmp(tcfg.sof_high_etu, o[TF_SOF_HIGH] ? SOF_HIGH_LONG_ETU : SOF_HIGH_SHORT_ETU);
      cmp(tcfg.sof_low_etu, !isb ? 4'd0 : o[TF_SOF_LOW] ? SOF_LOW_LONG_ETU : SOF_LOW_SHORT_ETU);
      cmp(tcfg.guard_etu, isb ? o[7:TF_GUARD_LSB] : 3'd0);
      cmp(sak, (isa && auto_ac) ? {1'b0, o[TF_LAYER4], 6'd0} : 8'h00);
   endtask : check_tx
   task automatic guard_run(input logic last, input int exp);
      rps_framer_model_inst.send_char(last);
      n = 0;
      for (int j = 0; j < 100; j++) begin
         #1;
         if (ready === 1'b1) break;
         n += tick;
         @(posedge clock);
      end
      cmp(n, exp);
   endtask : guard_run
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   // ****************************************************************
   // clock, watchdog, tests
   // ****************************************************************
   initial forever #10 clock = ~clock;
   initial begin
      #400000;
      error_cnt++;
      report_and_stop;
   end
   initial begin
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      bus_read(PROTO_SEL_IDX, {24'h0000_00, PROTO_SEL_RST});
      bus_read(TX_FRAME_IDX, {24'h0000_00, TX_FRAME_RST});
      check_proto(8'h02);
      for (int c = 0; c < 64; c++) begin
         bus_write(PROTO_SEL_IDX, 8'(c));
         check_proto(8'(c));
      end
      bus_write(TX_FRAME_IDX, 8'h5A);
      bus(1'b1, TX_FRAME_IDX, 32'h0000_00C3, 4'hE);
      bus_read(TX_FRAME_IDX, 32'h0000_005A);
      bus_write(8'h03, 8'hE0);
      bus_read(8'h03, UNMAPPED_DATA);
      bus_write(8'h20, 8'hFF);
      bus_read(8'h20, UNMAPPED_DATA);
      for (int k = 0; k < 32; k++) begin
         @(posedge clock);
         auto_ac <= k[4];
         bus_write(PROTO_SEL_IDX, protos[k[3:2]]);
         bus_write(TX_FRAME_IDX, opts[k[1:0]]);
         check_tx(protos[k[3:2]], opts[k[1:0]]);
      end
      bus_write(PROTO_SEL_IDX, 8'h0C);
      for (int k = 0; k < 32; k++) begin
         bus_write(TX_FRAME_IDX, {k[4:2], 3'b000, k[0], 1'b0});
         guard_run(k[1], (k[0] || !k[1]) ? k[4:2] : 0);
      end
      bus_write(PROTO_SEL_IDX, 8'h08);
      guard_run(1'b0, 0);
      @(posedge clock);
      enable <= 1'b0;
      @(posedge clock);
      enable <= 1'b1;
      bus_read(PROTO_SEL_IDX, {24'h0000_00, PROTO_SEL_RST});
      bus_read(TX_FRAME_IDX, {24'h0000_00, TX_FRAME_RST});
      bus_read(CFG_STATUS_IDX, 32'h0000_0020);
      report_and_stop;
   end
endmodule : rps_top_tb
